// ---- hw/fids_pkg.sv ----
`default_nettype none
package fids_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_ID_PAIR_SINGLE = 8'h90;
  localparam logic [7:0] OP_ID_PAIR_DUAL = 8'h92;
  localparam logic [7:0] OP_ID_PAIR_QUAD = 8'h94;
  localparam logic [7:0] OP_ID_THREE = 8'h9F;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_READ_HI = 8'h35;
  localparam logic [7:0] OP_CONFIG_READ = 8'h15;
  localparam logic [7:0] OP_SECURE_READ = 8'h48;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  // ==========================================================
  // id order selectors
  localparam logic [7:0] ID_ADDR_MAKER_FIRST = 8'h00;
  localparam logic [7:0] ID_ADDR_PART_FIRST = 8'h01;
  // status bit position of the suspend flag
  localparam int STATUS_SUSPEND_BIT = 15;
  // ==========================================================
  // timing
  localparam int CLOCK_MHZ = 100;
  localparam int SUSPEND_LATENCY_US = 30;
  localparam int SUSPEND_LATENCY_CYCLES = SUSPEND_LATENCY_US * CLOCK_MHZ;
  // identity values: arbitrary
  localparam logic [7:0] MAKER_CODE = 8'hA5;
  localparam logic [7:0] PAIR_PART_CODE = 8'h3C;
  localparam logic [15:0] THREE_PART_CODE = 16'h5A3C;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_DUMMY = 3'b010,
    ST_ADDR = 3'b011,
    ST_OUT = 3'b100,
    ST_SKIP = 3'b101
  } fids_state_t;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } fids_dq_t;
  typedef struct packed {
    logic write_enable_latch;
    logic write_in_progress;
    logic suspend_flag;
  } fids_status_t;
endpackage : fids_pkg
`default_nettype wire

// ---- hw/fids_core.sv ----
`default_nettype none
// How it works
// (RQ1) opcode 90h, two dummy bytes and one address byte on one wire start the id pair readout.
// (RQ2) id bits leave on the falling serial clock edge, msb first.
// (RQ3) address 00h gives maker then part, 01h gives part then maker.
// (RQ4) the pair repeats alternately until chip select rises, which ends the command.
// (RQ5) opcode 92h does the same with address and data on lines 0 and 1.
// (RQ6) opcode 94h does the same with address and data on lines 0 to 3.
// (RQ7) opcode 9Fh returns 24 bits: maker byte then two part bytes.
// (RQ8) chip select rising anywhere in the readout ends it and returns to standby.
// (RQ9) the three-byte id command is not decoded while program or erase runs.
// (RQ10) suspend pauses page program or sector/block erase; the busy region stays unreadable.
// (RQ11) after suspend the latency elapses, then the latch clears, the flag sets and reads open.
// (RQ12) status bit 15 shows the suspend flag, 1 while suspended and 0 after resume.
// (RQ13) status, secure area read, reset arm and reset are accepted at once after suspend.
// (RQ14) after the latency array reads such as 03h, 0Bh and EBh are accepted.
// (RQ15) resume 7Ah sets the latch and busy bit and clears the suspend flag at once.
// (RQ16) while suspended any command outside the allowed lists is ignored.
module fids_core #(
  parameter int SUSPEND_CYCLES = fids_pkg::SUSPEND_LATENCY_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] dq_in,
  output fids_pkg::fids_dq_t dq_out,
  input wire logic op_running,
  input wire logic op_start,
  output logic op_paused,
  output logic [15:0] status_word,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic region_blocked
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] cs_s1_ff, cs_s2_ff, ck_s1_ff, ck_s2_ff;
  logic [3:0] dq_s1_ff, dq_s2_ff;
  logic cs_q_ff, ck_q_ff;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cs_s1_ff <= 3'h7;
      cs_s2_ff <= 3'h7;
      ck_s1_ff <= 3'h0;
      ck_s2_ff <= 3'h0;
      dq_s1_ff <= 4'h0;
      dq_s2_ff <= 4'h0;
      cs_q_ff <= 1'b1;
      ck_q_ff <= 1'b0;
    end else begin
      cs_s1_ff <= {3{cs_n}};
      cs_s2_ff <= cs_s1_ff;
      ck_s1_ff <= {3{sclk}};
      ck_s2_ff <= ck_s1_ff;
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      cs_q_ff <= cs_s2_ff[0];
      ck_q_ff <= ck_s2_ff[0];
    end
  end
  logic sel, rise, fall, cs_up;
  assign sel = !cs_s2_ff[0];
  assign rise = sel && ck_s2_ff[0] && !ck_q_ff;
  assign fall = sel && !ck_s2_ff[0] && ck_q_ff;
  assign cs_up = cs_s2_ff[0] && !cs_q_ff;

  // ==========================================================
  // frame decoder
  fids_pkg::fids_state_t state_ff;
  logic [7:0] shift_ff, opcode_ff, addr_ff;
  logic [4:0] bitcnt_ff;
  logic [2:0] width_ff;
  logic dummy_left_ff;
  logic [23:0] out_ff;
  logic [4:0] outcnt_ff;
  logic three_ff, maker_next_ff;
  logic [7:0] byte_in;
  logic [4:0] byte_bits;
  logic susp_ff, waiting_ff, wel_ff, wip_ff;
  logic [$clog2(SUSPEND_CYCLES+1)-1:0] lat_ff;

  // one-wire shifting of the opcode; multi-wire after it for 92h and 94h
  always_comb begin
    byte_in = shift_ff;
    byte_bits = 5'd8;
    case (width_ff)
      3'd2: begin
        byte_in = {shift_ff[5:0], dq_s2_ff[1:0]};
        byte_bits = 5'd4;
      end
      3'd4: begin
        byte_in = {shift_ff[3:0], dq_s2_ff};
        byte_bits = 5'd2;
      end
      default: begin
        byte_in = {shift_ff[6:0], dq_s2_ff[0]};
        byte_bits = 5'd8;
      end
    endcase
  end

  function automatic logic allowed(input logic [7:0] op, input logic open_reads);
    logic quick;
    quick = op inside {fids_pkg::OP_STATUS_READ, fids_pkg::OP_STATUS_READ_HI, fids_pkg::OP_CONFIG_READ,
                       fids_pkg::OP_SECURE_READ, fids_pkg::OP_RESET_ARM, fids_pkg::OP_RESET,
                       fids_pkg::OP_NOP, fids_pkg::OP_SIGNATURE}; // [RQ13]
    allowed = quick || (open_reads && (op inside {fids_pkg::OP_READ, fids_pkg::OP_FAST_READ,
      fids_pkg::OP_QUAD_IO_READ, fids_pkg::OP_ID_PAIR_SINGLE, fids_pkg::OP_ID_PAIR_DUAL,
      fids_pkg::OP_ID_PAIR_QUAD, fids_pkg::OP_ID_THREE, fids_pkg::OP_RESUME})); // [RQ14]
  endfunction : allowed

  logic byte_done, accept;
  assign byte_done = rise && (bitcnt_ff + 5'd1 == byte_bits);
  // suspended or waiting: only listed commands pass [RQ16]
  assign accept = !(susp_ff || waiting_ff) || allowed(byte_in, susp_ff);

  always_ff @(posedge clock) begin
    if (!resetn || cs_up) begin // [RQ8] [RQ4]
      state_ff <= fids_pkg::ST_IDLE;
      bitcnt_ff <= 5'd0;
      width_ff <= 3'd1;
      shift_ff <= 8'h00;
      opcode_ff <= 8'h00;
      addr_ff <= 8'h00;
      dummy_left_ff <= 1'b0;
      three_ff <= 1'b0;
    end else begin
      if (state_ff == fids_pkg::ST_IDLE && sel) state_ff <= fids_pkg::ST_OPCODE;
      if (rise && state_ff != fids_pkg::ST_OUT && state_ff != fids_pkg::ST_SKIP) begin
        shift_ff <= byte_in;
        bitcnt_ff <= byte_done ? 5'd0 : bitcnt_ff + 5'd1;
      end
      if (byte_done) begin
        case (state_ff)
          fids_pkg::ST_OPCODE: begin
            opcode_ff <= byte_in;
            if (!accept) state_ff <= fids_pkg::ST_SKIP;
            else if (byte_in == fids_pkg::OP_ID_PAIR_SINGLE) state_ff <= fids_pkg::ST_DUMMY; // [RQ1]
            else if (byte_in == fids_pkg::OP_ID_PAIR_DUAL) begin
              state_ff <= fids_pkg::ST_DUMMY;
              width_ff <= 3'd2; // [RQ5]
            end else if (byte_in == fids_pkg::OP_ID_PAIR_QUAD) begin
              state_ff <= fids_pkg::ST_DUMMY;
              width_ff <= 3'd4; // [RQ6]
            end else if (byte_in == fids_pkg::OP_ID_THREE && !(op_running && !susp_ff)) begin // [RQ9]
              state_ff <= fids_pkg::ST_OUT;
              three_ff <= 1'b1;
            end else state_ff <= fids_pkg::ST_SKIP;
            dummy_left_ff <= 1'b1;
          end
          fids_pkg::ST_DUMMY: begin
            dummy_left_ff <= 1'b0;
            if (!dummy_left_ff) state_ff <= fids_pkg::ST_ADDR;
          end
          fids_pkg::ST_ADDR: begin
            addr_ff <= byte_in;
            state_ff <= fids_pkg::ST_OUT;
          end
          default: state_ff <= state_ff;
        endcase
      end
    end
  end
  // a three-byte id arriving while the array is busy is not decoded, so it is not reported either [RQ9]
  assign cmd_valid = byte_done && state_ff == fids_pkg::ST_OPCODE && accept &&
    !(byte_in == fids_pkg::OP_ID_THREE && op_running && !susp_ff);
  assign cmd_code = byte_in;

  // ==========================================================
  // id output shifter, driven on falling serial clock
  logic load_out;
  assign load_out = byte_done && (state_ff == fids_pkg::ST_ADDR ||
    (state_ff == fids_pkg::ST_OPCODE && accept && byte_in == fids_pkg::OP_ID_THREE && !(op_running && !susp_ff)));
  always_ff @(posedge clock) begin
    if (!resetn || cs_up) begin
      out_ff <= 24'h000000;
      outcnt_ff <= 5'd0;
      maker_next_ff <= 1'b0;
      dq_out <= '0;
    end else if (load_out) begin
      outcnt_ff <= 5'd0;
      if (state_ff == fids_pkg::ST_OPCODE)
        out_ff <= {fids_pkg::MAKER_CODE, fids_pkg::THREE_PART_CODE}; // [RQ7]
      else if (byte_in == fids_pkg::ID_ADDR_PART_FIRST) begin
        out_ff <= {fids_pkg::PAIR_PART_CODE, 16'h0000}; // [RQ3]
        maker_next_ff <= 1'b1;
      end else begin
        out_ff <= {fids_pkg::MAKER_CODE, 16'h0000}; // [RQ3]
        maker_next_ff <= 1'b0;
      end
    end else if (fall && state_ff == fids_pkg::ST_OUT) begin
      // msb first on the falling edge [RQ2]
      case (width_ff)
        3'd2: dq_out <= '{o: {2'b00, out_ff[23:22]}, oe: 4'h3};
        3'd4: dq_out <= '{o: out_ff[23:20], oe: 4'hF};
        default: dq_out <= '{o: {2'b00, out_ff[23], 1'b0}, oe: 4'h2};
      endcase
      if (three_ff) begin
        out_ff <= {out_ff[22:0], 1'b0};
        if (outcnt_ff == 5'd23) outcnt_ff <= 5'd0;
        else outcnt_ff <= outcnt_ff + 5'd1;
      end else if (outcnt_ff + 5'd1 == byte_bits) begin
        // alternate maker and part codes [RQ4]
        out_ff <= {maker_next_ff ? fids_pkg::MAKER_CODE : fids_pkg::PAIR_PART_CODE, 16'h0000};
        maker_next_ff <= !maker_next_ff;
        outcnt_ff <= 5'd0;
      end else begin
        out_ff <= (width_ff == 3'd4) ? {out_ff[19:0], 4'h0} :
                  (width_ff == 3'd2) ? {out_ff[21:0], 2'b00} : {out_ff[22:0], 1'b0};
        outcnt_ff <= outcnt_ff + 5'd1;
      end
    end
  end

  // ==========================================================
  // suspend and resume; latch and busy bits
  logic cmd_commit;
  assign cmd_commit = cs_up && (opcode_ff == fids_pkg::OP_SUSPEND || opcode_ff == fids_pkg::OP_RESUME);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      susp_ff <= 1'b0;
      waiting_ff <= 1'b0;
      wel_ff <= 1'b0;
      wip_ff <= 1'b0;
      lat_ff <= '0;
    end else begin
      if (op_start) begin
        wip_ff <= 1'b1;
        wel_ff <= 1'b1;
      end else if (!op_running && !susp_ff && !waiting_ff) begin
        wip_ff <= 1'b0;
        wel_ff <= 1'b0;
      end
      if (cmd_commit && opcode_ff == fids_pkg::OP_SUSPEND && op_running && !susp_ff && !waiting_ff) begin
        waiting_ff <= 1'b1; // [RQ10]
        lat_ff <= '0;
      end else if (waiting_ff) begin
        if (lat_ff == ($clog2(SUSPEND_CYCLES+1))'(SUSPEND_CYCLES - 1)) begin
          waiting_ff <= 1'b0;
          susp_ff <= 1'b1; // [RQ11]
          wel_ff <= 1'b0;
          wip_ff <= 1'b0;
        end else lat_ff <= lat_ff + 1'b1;
      end else if (cmd_commit && opcode_ff == fids_pkg::OP_RESUME && susp_ff) begin
        susp_ff <= 1'b0; // [RQ15]
        wel_ff <= 1'b1;
        wip_ff <= 1'b1;
      end
    end
  end
  assign op_paused = susp_ff;
  assign region_blocked = susp_ff; // busy region reads refused by the array side [RQ10]
  always_comb begin
    status_word = 16'h0000;
    status_word[fids_pkg::STATUS_SUSPEND_BIT] = susp_ff; // [RQ12]
    status_word[1] = wel_ff;
    status_word[0] = wip_ff;
  end
endmodule : fids_core
`default_nettype wire

// ---- tb/fids_asserts.sv ----
`default_nettype none
module fids_asserts #(
  parameter int SUSPEND_CYCLES = 10
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] dq_in,
  input wire fids_pkg::fids_dq_t dq_out,
  input wire logic op_running,
  input wire logic op_start,
  input wire logic op_paused,
  input wire logic [15:0] status_word,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic region_blocked
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // properties
  chk_cs_release: assert property ($rose(cs_n) |-> ##[1:8] (dq_out.oe == 4'h0))
    else $error("data lines still driven after chip select rise");
  chk_out_stable: assert property ((sclk && $past(sclk, 6) && !cs_n) |-> $stable(dq_out))
    else $error("data output moved while serial clock high");
  chk_flag_status: assert property (status_word[15] == op_paused)
    else $error("status bit 15 differs from suspend flag");
  chk_suspend_wel: assert property ($rose(op_paused) |-> !status_word[1] && region_blocked)
    else $error("suspend entered with latch set or region open");
  chk_resume_set: assert property ($fell(op_paused) |-> status_word[1:0] == 2'b11)
    else $error("resume left latch or busy clear");
  chk_allowed_cmds: assert property ((cmd_valid && op_paused) |-> cmd_code inside {8'h03, 8'h0B, 8'h0D, 8'h3B,
    8'h6B, 8'hBB, 8'hBD, 8'hEB, 8'hE7, 8'hED, 8'h0C, 8'h0E, 8'h38, 8'hFF, 8'h5A, 8'h9F, 8'h90, 8'h92, 8'h94, 8'h77,
    8'hC0, 8'h06, 8'h7A, 8'h02, 8'h32, 8'h44, 8'h42, 8'h48, 8'h36, 8'h39, 8'h3D, 8'h7E, 8'h98, 8'h04, 8'h05, 8'h35,
    8'h15, 8'hAB, 8'h66, 8'h99, 8'h00})
    else $error("command accepted while suspended is not allowed");
  chk_id_busy: assert property ((cmd_valid && op_running && !op_paused) |-> cmd_code != fids_pkg::OP_ID_THREE)
    else $error("three byte id decoded during program or erase");
  chk_paused_hold: assert property ($rose(op_paused) |=> op_paused [*2])
    else $error("suspend flag dropped without resume");
  cov_three: cover property (cmd_valid && cmd_code == fids_pkg::OP_ID_THREE);
  cov_suspend: cover property ($rose(op_paused));
  cov_resume: cover property ($fell(op_paused));
endmodule : fids_asserts
bind fids_core fids_asserts #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) fids_asserts_inst (.clock(clock), .resetn(resetn),
  .cs_n(cs_n), .sclk(sclk), .dq_in(dq_in), .dq_out(dq_out), .op_running(op_running), .op_start(op_start),
  .op_paused(op_paused), .status_word(status_word), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .region_blocked(region_blocked));
`default_nettype wire

// ---- tb/fids_host.sv ----
`default_nettype none
module fids_host (
  input wire logic clock,
  input wire fids_pkg::fids_dq_t dq_out,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    dq_in = 4'h0;
  end
  // ==========================================================
  // serial clock halves of 80 ns, sclk idles low between frames
  task automatic half();
    repeat (7) @(posedge clock);
  endtask : half
  // msb first, msb on the highest line in use
  task automatic send(input logic [7:0] b, input int w);
    for (int i = 7; i >= 0; i -= w) begin
      @(posedge clock);
      sclk <= 1'b0;
      dq_in <= (w == 1) ? {3'h0, b[i]} : (w == 2) ? {2'h0, b[i -: 2]} : b[i -: 4];
      half();
      @(posedge clock);
      sclk <= 1'b1;
      half();
    end
  endtask : send
  task automatic recv(input int w, input int n, output logic [31:0] v);
    v = '0;
    for (int i = 0; i < n; i += w) begin
      @(posedge clock);
      sclk <= 1'b0;
      dq_in <= ~dq_in; // released lines toggle so stale data cannot pass
      half();
      @(negedge clock);
      v = (w == 1) ? {v[30:0], dq_out.o[1]} : (w == 2) ? {v[29:0], dq_out.o[1:0]} : {v[27:0], dq_out.o};
      @(posedge clock);
      sclk <= 1'b1;
      half();
    end
  endtask : recv
  task automatic frame(input logic [7:0] op, input int w, input bit adr, input logic [7:0] a, input int n,
      output logic [31:0] v);
    @(posedge clock);
    cs_n <= 1'b0;
    half();
    send(op, 1);
    if (adr) begin
      send(8'h00, w);
      send(8'h00, w);
      send(a, w);
    end
    recv(w, n, v);
    @(posedge clock);
    sclk <= 1'b0;
    half();
    @(posedge clock);
    cs_n <= 1'b1; // may end anywhere in the readout
    dq_in <= ~dq_in;
    half();
    @(negedge clock);
  endtask : frame
endmodule : fids_host
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, op_running, op_start, cs_n, sclk, cmd_valid, op_paused, region_blocked, seen_oe;
  logic [3:0] dq_in;
  logic [7:0] cmd_code, got_code;
  logic [15:0] status_word;
  logic [31:0] v;
  fids_pkg::fids_dq_t dq_out;
  int errors, checks;
  fids_core #(.SUSPEND_CYCLES(600)) fids_core_inst (.clock(clock), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
    .dq_in(dq_in), .dq_out(dq_out), .op_running(op_running), .op_start(op_start), .op_paused(op_paused),
    .status_word(status_word), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .region_blocked(region_blocked));
  fids_host fids_host_inst (.clock(clock), .dq_out(dq_out), .cs_n(cs_n), .sclk(sclk), .dq_in(dq_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // strobe sampled mid-cycle, away from the register updates
  always @(negedge clock) begin
    if (cmd_valid === 1'b1) got_code <= cmd_code;
    if (dq_out.oe !== 4'h0) seen_oe <= 1'b1;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // scenarios
  task automatic t_pair();
    logic [7:0] ops [3] = '{fids_pkg::OP_ID_PAIR_SINGLE, fids_pkg::OP_ID_PAIR_DUAL, fids_pkg::OP_ID_PAIR_QUAD};
    logic [15:0] pr;
    for (int k = 0; k < 6; k++) begin
      fids_host_inst.frame(ops[k / 2], 1 << (k / 2), 1'b1, 8'(k % 2), 32, v);
      pr = (k % 2) ? {fids_pkg::PAIR_PART_CODE, fids_pkg::MAKER_CODE} : {fids_pkg::MAKER_CODE, fids_pkg::PAIR_PART_CODE};
      chk("id pair", {pr, pr}, v);
      chk("pair released", 32'h0, {28'h0, dq_out.oe});
    end
  endtask : t_pair
  task automatic t_three();
    fids_host_inst.frame(fids_pkg::OP_ID_THREE, 1, 1'b0, 8'h00, 32, v);
    chk("three id", {fids_pkg::MAKER_CODE, fids_pkg::THREE_PART_CODE, 8'h00}, v);
    fids_host_inst.frame(fids_pkg::OP_ID_THREE, 1, 1'b0, 8'h00, 12, v);
    chk("three id cut", {20'h0, fids_pkg::MAKER_CODE, fids_pkg::THREE_PART_CODE[15:12]}, v);
    chk("cut released", 32'h0, {28'h0, dq_out.oe});
  endtask : t_three
  task automatic t_busy();
    @(posedge clock);
    op_start <= 1'b1;
    op_running <= 1'b1;
    @(posedge clock);
    op_start <= 1'b0;
    seen_oe = 1'b0;
    got_code = 8'hEE;
    fids_host_inst.frame(fids_pkg::OP_ID_THREE, 1, 1'b0, 8'h00, 24, v);
    chk("busy id code", 32'hEE, {24'h0, got_code});
    chk("busy id drive", 32'h0, {31'h0, seen_oe});
    chk("busy status", 32'h3, {16'h0, status_word});
  endtask : t_busy
  task automatic t_suspend();
    logic [7:0] early [3] = '{fids_pkg::OP_STATUS_READ, fids_pkg::OP_SECURE_READ, fids_pkg::OP_RESET_ARM};
    fids_host_inst.frame(fids_pkg::OP_SUSPEND, 1, 1'b0, 8'h00, 0, v);
    for (int k = 0; k < 3; k++) begin
      got_code = 8'hEE;
      fids_host_inst.frame(early[k], 1, 1'b0, 8'h00, 0, v);
      chk("early command", {24'h0, early[k]}, {24'h0, got_code});
    end
    chk("flag in latency", 32'h0, {31'h0, op_paused});
    for (int i = 0; i < 1000 && op_paused !== 1'b1; i++) @(negedge clock);
    if (op_paused !== 1'b1) begin
      errors++;
      wrap_up();
    end
    chk("suspended status", 32'h8000, {16'h0, status_word});
    chk("region blocked", 32'h1, {31'h0, region_blocked});
    got_code = 8'hEE;
    fids_host_inst.frame(fids_pkg::OP_READ, 1, 1'b0, 8'h00, 0, v);
    chk("read in suspend", 32'h03, {24'h0, got_code});
    got_code = 8'hEE;
    fids_host_inst.frame(8'h20, 1, 1'b0, 8'h00, 0, v);
    chk("erase in suspend", 32'hEE, {24'h0, got_code});
    fids_host_inst.frame(fids_pkg::OP_RESUME, 1, 1'b0, 8'h00, 0, v);
    chk("resumed status", 32'h0003, {16'h0, status_word});
  endtask : t_suspend
  initial begin
    resetn = 1'b0;
    op_running = 1'b0;
    op_start = 1'b0;
    got_code = 8'hEE;
    seen_oe = 1'b0;
    errors = 0;
    checks = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (5) @(posedge clock);
    t_pair();
    t_three();
    t_busy();
    t_suspend();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
